/* rtl/fp_convert_zero_condmove_ops.sv */
// Decode and execute logic for unsigned-to-float conversion, register clear and
// conditional low-half load. Assumes the host core respects the conversion delay
// slot and answers each memory request with one mem_rdata_valid pulse.
//
// Summary of operation
// [RQ1] Low word e68f with source in high bits 5:3 and destination in bits 2:0 is the register half-word conversion.
// [RQ2] The half-word conversion takes only source bits 15:0 as unsigned and writes its exact float value.
// [RQ3] Low word e2c4 reads a 16-bit memory operand and converts it into the register named by bits 10:8.
// [RQ4] Low word e284 reads a 32-bit unsigned memory operand and converts it into the named register.
// [RQ5] Low word e68b converts the whole 32-bit source register as unsigned into a float.
// [RQ6] Conversions take two pipeline cycles, and the next instruction must not touch their destination.
// [RQ7] Conversions leave every status flag unchanged.
// [RQ8] One-word e590 to e597 sets the high register chosen by its low three bits to zero.
// [RQ9] One-word e563 sets all eight high registers to zero and leaves the flags alone.
// [RQ10] Both clears finish in one cycle, so the very next instruction sees zero.
// [RQ11] Three-bit select fields address registers zero to seven, destination and source.
// [RQ12] Low word e29 plus a four-bit condition is the conditional low-half load, destination in bits 10:8.
// [RQ13] A true condition writes the memory word to the low register and leaves the high one; false writes nothing.
// [RQ14] The condition field covers the equality, sign, test-flag, latched and two unconditional codes, others reserved.
// [RQ15] Only the always-with-flag-update code changes the zero and negative flags from the loaded word.
// [RQ16] The issuing side encodes always-with-flag-update when no condition is written.
// [RQ17] Memory operands come through the host read path and the block stalls until the word arrives.
`timescale 1ns/100ps
module fp_convert_zero_condmove_ops (
  input wire logic clk_sys, // System clock, 10 MHz.
  input wire logic reset, // Synchronous reset, active high.
  input wire logic instr_valid, // Instruction offered this cycle.
  input wire fp_cvt_pkg::instr_t instr, // Both instruction words.
  output logic instr_ready, // Instruction taken when high with instr_valid.
  output logic mem_req, // Memory operand wanted, held until delivered.
  output logic [7:0] mem_operand, // Memory field of the high word.
  output logic mem_wide, // High for a 32-bit operand, low for 16-bit.
  input wire logic mem_rdata_valid, // Memory word delivered this cycle.
  input wire logic [31:0] mem_rdata, // Memory word; 16-bit reads use bits 15:0.
  input wire logic flag_wr, // Load the status register from flag_wdata.
  input wire fp_cvt_pkg::fp_status_register_t flag_wdata, // Flags from other instructions.
  output fp_cvt_pkg::fp_status_register_t flags, // Current status register.
  input wire logic [2:0] rd_sel, // Register pair to read back.
  output fp_cvt_pkg::reg_pair_t rd_data, // Registered read-back of that pair.
  output logic illegal_op // One-cycle pulse for an accepted unknown opcode.
);

  // Exact for 16-bit inputs; 32-bit inputs round to nearest, ties to even.
  function automatic logic [31:0] u32_to_f32(input logic [31:0] v);
    logic [4:0] msb;
    logic [31:0] norm;
    logic [24:0] rnd;
    logic [7:0] expo;
    msb = 5'h00;
    for (int i = 0; i < 32; i++)
    begin
      if (v[i])
        msb = 5'(i);
    end
    norm = v << (5'h1f - msb);
    rnd = {1'b0, norm[31:8]} + 25'(norm[7] && ((|norm[6:0]) || norm[8]));
    expo = 8'h7f + {3'h0, msb};
    if (v == 32'h0000_0000)
      u32_to_f32 = 32'h0000_0000;
    else if (rnd[24])
      u32_to_f32 = {1'b0, expo + 8'h01, 23'h000000};
    else
      u32_to_f32 = {1'b0, expo, rnd[22:0]};
  endfunction

  // Opcode decode; used for the live instruction and for the word waiting on memory.
  function automatic fp_cvt_pkg::op_t decode(input logic [15:0] lsw);
    if (lsw == fp_cvt_pkg::OPC_HALF_REG)
      decode = fp_cvt_pkg::op_half_reg; // [RQ1]
    else if (lsw == fp_cvt_pkg::OPC_WORD_REG)
      decode = fp_cvt_pkg::op_word_reg; // [RQ5]
    else if (lsw == fp_cvt_pkg::OPC_HALF_MEM)
      decode = fp_cvt_pkg::op_half_mem; // [RQ3]
    else if (lsw == fp_cvt_pkg::OPC_WORD_MEM)
      decode = fp_cvt_pkg::op_word_mem; // [RQ4]
    else if (lsw == fp_cvt_pkg::OPC_CLEAR_ALL)
      decode = fp_cvt_pkg::op_clear_all; // [RQ9]
    else if (lsw[15:3] == fp_cvt_pkg::OPC_CLEAR_ONE_TOP)
      decode = fp_cvt_pkg::op_clear_one; // [RQ8]
    else if (lsw[15:4] == fp_cvt_pkg::OPC_COND_LOAD_TOP)
      decode = fp_cvt_pkg::op_cond_load; // [RQ12]
    else
      decode = fp_cvt_pkg::op_none;
  endfunction

  // Condition test against the status register; reserved codes never pass.
  function automatic logic cond_true(input logic [3:0] c, input fp_cvt_pkg::fp_status_register_t f);
    case (c) // [RQ14]
      fp_cvt_pkg::COND_NEQ: cond_true = !f.float_zero_flag;
      fp_cvt_pkg::COND_EQ: cond_true = f.float_zero_flag;
      fp_cvt_pkg::COND_GT: cond_true = !f.float_zero_flag && !f.float_negative_flag;
      fp_cvt_pkg::COND_GEQ: cond_true = !f.float_negative_flag;
      fp_cvt_pkg::COND_LT: cond_true = f.float_negative_flag;
      fp_cvt_pkg::COND_LEQ: cond_true = f.float_zero_flag || f.float_negative_flag;
      fp_cvt_pkg::COND_TF: cond_true = f.test_flag;
      fp_cvt_pkg::COND_NTF: cond_true = !f.test_flag;
      fp_cvt_pkg::COND_LU: cond_true = f.latched_underflow_flag;
      fp_cvt_pkg::COND_LV: cond_true = f.latched_overflow_flag;
      fp_cvt_pkg::ALWAYS_NO_FLAGS: cond_true = 1'b1;
      fp_cvt_pkg::ALWAYS_WITH_FLAG_UPDATE: cond_true = 1'b1;
      default: cond_true = 1'b0;
    endcase
  endfunction

  fp_cvt_pkg::state_t state_q, state_d;
  fp_cvt_pkg::instr_t held_q, held_d;
  logic [7:0] mem_operand_q, mem_operand_d;
  logic mem_wide_q, mem_wide_d;
  logic illegal_q, illegal_d;
  logic pend_valid_q, pend_valid_d;
  logic [2:0] pend_dest_q, pend_dest_d;
  logic [31:0] pend_val_q, pend_val_d;
  logic [31:0] hi_q [fp_cvt_pkg::NUM_REGS];
  logic [31:0] hi_d [fp_cvt_pkg::NUM_REGS];
  logic [31:0] lo_q [fp_cvt_pkg::NUM_REGS];
  logic [31:0] lo_d [fp_cvt_pkg::NUM_REGS];
  fp_cvt_pkg::fp_status_register_t flags_q, flags_d;
  fp_cvt_pkg::reg_pair_t rd_q, rd_d;

  logic accept;
  fp_cvt_pkg::op_t op_in, op_held;
  logic [2:0] dest_sel, src_sel, mem_dest;
  logic mem_done;
  logic [3:0] held_cond;

  // Decode of the offered word and of the word waiting on memory.
  assign instr_ready = (state_q == fp_cvt_pkg::st_idle);
  assign accept = instr_valid && instr_ready;
  assign op_in = decode(instr.lsw);
  assign op_held = decode(held_q.lsw);
  assign dest_sel = instr.msw[fp_cvt_pkg::DEST_LSB +: fp_cvt_pkg::SEL_W]; // [RQ11]
  assign src_sel = instr.msw[fp_cvt_pkg::SRC_LSB +: fp_cvt_pkg::SEL_W]; // [RQ11]
  assign mem_dest = held_q.msw[fp_cvt_pkg::MEM_DEST_LSB +: fp_cvt_pkg::SEL_W];
  assign held_cond = held_q.lsw[3:0];
  assign mem_done = (state_q == fp_cvt_pkg::st_wait_mem) && mem_rdata_valid;

  // Issue control: memory forms park the instruction and stall until the word comes back.
  always_comb
  begin
    state_d = state_q;
    held_d = held_q;
    mem_operand_d = mem_operand_q;
    mem_wide_d = mem_wide_q;
    illegal_d = 1'b0;
    case (state_q)
      fp_cvt_pkg::st_idle:
      begin
        if (accept)
        begin
          illegal_d = (op_in == fp_cvt_pkg::op_none);
          if (op_in == fp_cvt_pkg::op_half_mem || op_in == fp_cvt_pkg::op_word_mem ||
              op_in == fp_cvt_pkg::op_cond_load)
          begin
            state_d = fp_cvt_pkg::st_wait_mem; // [RQ17]
            held_d = instr;
            mem_operand_d = instr.msw[fp_cvt_pkg::MEM_FIELD_W-1:0];
            mem_wide_d = (op_in != fp_cvt_pkg::op_half_mem);
          end
        end
      end
      fp_cvt_pkg::st_wait_mem:
      begin
        if (mem_rdata_valid)
          state_d = fp_cvt_pkg::st_idle; // [RQ17]
      end
      default: state_d = fp_cvt_pkg::st_idle;
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      state_q <= fp_cvt_pkg::st_idle;
      held_q <= '0;
      mem_operand_q <= 8'h00;
      mem_wide_q <= 1'b0;
      illegal_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      held_q <= held_d;
      mem_operand_q <= mem_operand_d;
      mem_wide_q <= mem_wide_d;
      illegal_q <= illegal_d;
    end
  end

  // Conversion stage: the result lands one cycle after the operand is in hand,
  // which is what gives the single delay slot.
  always_comb
  begin
    pend_valid_d = 1'b0;
    pend_dest_d = pend_dest_q;
    pend_val_d = pend_val_q;
    if (accept && op_in == fp_cvt_pkg::op_half_reg)
    begin
      pend_valid_d = 1'b1; // [RQ6]
      pend_dest_d = dest_sel;
      pend_val_d = u32_to_f32({16'h0000, hi_q[src_sel][15:0]}); // [RQ2]
    end
    else if (accept && op_in == fp_cvt_pkg::op_word_reg)
    begin
      pend_valid_d = 1'b1; // [RQ6]
      pend_dest_d = dest_sel;
      pend_val_d = u32_to_f32(hi_q[src_sel]); // [RQ5]
    end
    else if (mem_done && op_held == fp_cvt_pkg::op_half_mem)
    begin
      pend_valid_d = 1'b1; // [RQ6]
      pend_dest_d = mem_dest;
      pend_val_d = u32_to_f32({16'h0000, mem_rdata[15:0]}); // [RQ3]
    end
    else if (mem_done && op_held == fp_cvt_pkg::op_word_mem)
    begin
      pend_valid_d = 1'b1; // [RQ6]
      pend_dest_d = mem_dest;
      pend_val_d = u32_to_f32(mem_rdata); // [RQ4]
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      pend_valid_q <= 1'b0;
      pend_dest_q <= 3'h0;
      pend_val_q <= 32'h0000_0000;
    end
    else
    begin
      pend_valid_q <= pend_valid_d;
      pend_dest_q <= pend_dest_d;
      pend_val_q <= pend_val_d;
    end
  end

  // Register file and flags. A clear issued in the slot lands after the older
  // pending conversion, so the clear wins; conversions never touch the flags.
  always_comb
  begin
    hi_d = hi_q;
    lo_d = lo_q;
    flags_d = flags_q; // [RQ7]
    if (flag_wr)
      flags_d = flag_wdata;
    if (pend_valid_q)
      hi_d[pend_dest_q] = pend_val_q; // [RQ6]
    if (accept && op_in == fp_cvt_pkg::op_clear_one)
      hi_d[instr.lsw[fp_cvt_pkg::DEST_LSB +: fp_cvt_pkg::SEL_W]] = fp_cvt_pkg::REG_RESET; // [RQ8] [RQ10]
    if (accept && op_in == fp_cvt_pkg::op_clear_all)
    begin
      for (int i = 0; i < fp_cvt_pkg::NUM_REGS; i++)
        hi_d[i] = fp_cvt_pkg::REG_RESET; // [RQ9] [RQ10]
    end
    if (mem_done && op_held == fp_cvt_pkg::op_cond_load && cond_true(held_cond, flags_q))
    begin
      lo_d[mem_dest] = mem_rdata; // [RQ13]
      if (held_cond == fp_cvt_pkg::ALWAYS_WITH_FLAG_UPDATE)
      begin
        flags_d.float_negative_flag = mem_rdata[31] && (mem_rdata[30:23] != 8'h00); // [RQ15]
        flags_d.float_zero_flag = (mem_rdata[30:23] == 8'h00); // [RQ15]
        flags_d.int_negative_flag = mem_rdata[31]; // [RQ15]
        flags_d.int_zero_flag = (mem_rdata == 32'h0000_0000); // [RQ15]
      end
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      for (int i = 0; i < fp_cvt_pkg::NUM_REGS; i++)
      begin
        hi_q[i] <= fp_cvt_pkg::REG_RESET;
        lo_q[i] <= fp_cvt_pkg::REG_RESET;
      end
      flags_q <= fp_cvt_pkg::FLAGS_RESET;
    end
    else
    begin
      hi_q <= hi_d;
      lo_q <= lo_d;
      flags_q <= flags_d;
    end
  end

  // Read-back port, registered so the data output is glitch free.
  always_comb
  begin
    rd_d.high = hi_q[rd_sel];
    rd_d.low = lo_q[rd_sel];
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
      rd_q <= '0;
    else
      rd_q <= rd_d;
  end

  assign mem_req = (state_q == fp_cvt_pkg::st_wait_mem);
  assign mem_operand = mem_operand_q;
  assign mem_wide = mem_wide_q;
  assign flags = flags_q;
  assign rd_data = rd_q;
  assign illegal_op = illegal_q;

  // Checks next to the logic they guard.
  sequence s_reg_conv;
    accept && (op_in == fp_cvt_pkg::op_half_reg || op_in == fp_cvt_pkg::op_word_reg);
  endsequence

  sequence s_load_done;
    mem_done && op_held == fp_cvt_pkg::op_cond_load;
  endsequence

  a_conv_one_slot: assert property (@(posedge clk_sys) disable iff (reset) // [RQ6]
    s_reg_conv |=> pend_valid_q && pend_dest_q == $past(dest_sel) ##1 (!pend_valid_q || $past(accept)))
    else $error("conversion result not staged for exactly one slot");

  a_conv_lands: assert property (@(posedge clk_sys) disable iff (reset) // [RQ6]
    (pend_valid_q && !(accept && (op_in == fp_cvt_pkg::op_clear_one || op_in == fp_cvt_pkg::op_clear_all)))
    |=> hi_q[$past(pend_dest_q)] == $past(pend_val_q))
    else $error("conversion result did not reach its register");

  a_half_positive: assert property (@(posedge clk_sys) disable iff (reset) // [RQ2]
    pend_valid_q |-> !pend_val_q[31] && pend_val_q[30:23] <= 8'h9f)
    else $error("unsigned conversion produced a negative or too large value");

  a_conv_flags_kept: assert property (@(posedge clk_sys) disable iff (reset) // [RQ7]
    (s_reg_conv or (mem_done && op_held != fp_cvt_pkg::op_cond_load)) ##0 !flag_wr |=> $stable(flags_q))
    else $error("conversion changed the status flags");

  a_clear_one_now: assert property (@(posedge clk_sys) disable iff (reset) // [RQ8]
    accept && op_in == fp_cvt_pkg::op_clear_one |=> hi_q[$past(instr.lsw[2:0])] == 32'h0000_0000)
    else $error("single clear did not zero its register in one cycle");

  a_clear_all_now: assert property (@(posedge clk_sys) disable iff (reset) // [RQ9]
    accept && op_in == fp_cvt_pkg::op_clear_all && !flag_wr
    |=> hi_q[0] == 32'h0 && hi_q[3] == 32'h0 && hi_q[7] == 32'h0 && $stable(flags_q))
    else $error("clear all left a register set or touched the flags");

  a_mem_stall: assert property (@(posedge clk_sys) disable iff (reset) // [RQ17]
    mem_req && !mem_rdata_valid |=> mem_req && !instr_ready)
    else $error("block left the memory wait without a word");

  a_load_keeps_high: assert property (@(posedge clk_sys) disable iff (reset) // [RQ13]
    s_load_done |=> hi_q[$past(mem_dest)] == $past(hi_q[mem_dest]) &&
    (lo_q[$past(mem_dest)] == ($past(cond_true(held_cond, flags_q)) ? $past(mem_rdata) : $past(lo_q[mem_dest]))))
    else $error("conditional load wrote the wrong half or ignored its condition");

  a_flag_update_only: assert property (@(posedge clk_sys) disable iff (reset) // [RQ15]
    s_load_done ##0 (held_cond != fp_cvt_pkg::ALWAYS_WITH_FLAG_UPDATE) ##0 !flag_wr |=> $stable(flags_q))
    else $error("conditional load changed flags without the update code");

endmodule

/* rtl/fp_cvt_pkg.sv */
// Package for the floating-point convert, clear and conditional-load block.
// Assumes one clock domain; the host core supplies instructions and memory words.
package fp_cvt_pkg;

  // Low opcode words; the conditional load matches on the upper twelve bits only.
  localparam logic [15:0] OPC_HALF_REG = 16'he68f;
  localparam logic [15:0] OPC_WORD_REG = 16'he68b;
  localparam logic [15:0] OPC_HALF_MEM = 16'he2c4;
  localparam logic [15:0] OPC_WORD_MEM = 16'he284;
  localparam logic [15:0] OPC_CLEAR_ALL = 16'he563;
  localparam logic [12:0] OPC_CLEAR_ONE_TOP = 13'h1cb2;
  localparam logic [11:0] OPC_COND_LOAD_TOP = 12'he29;

  // Field positions inside the instruction words.
  localparam int DEST_LSB = 0;
  localparam int SRC_LSB = 3;
  localparam int MEM_DEST_LSB = 8;
  localparam int SEL_W = 3;
  localparam int MEM_FIELD_W = 8;
  localparam int NUM_REGS = 8;

  // Condition field encodings; 0110 to 1001 are reserved and test false.
  localparam logic [3:0] COND_NEQ = 4'h0;
  localparam logic [3:0] COND_EQ = 4'h1;
  localparam logic [3:0] COND_GT = 4'h2;
  localparam logic [3:0] COND_GEQ = 4'h3;
  localparam logic [3:0] COND_LT = 4'h4;
  localparam logic [3:0] COND_LEQ = 4'h5;
  localparam logic [3:0] COND_TF = 4'ha;
  localparam logic [3:0] COND_NTF = 4'hb;
  localparam logic [3:0] COND_LU = 4'hc;
  localparam logic [3:0] COND_LV = 4'hd;
  localparam logic [3:0] ALWAYS_NO_FLAGS = 4'he;
  localparam logic [3:0] ALWAYS_WITH_FLAG_UPDATE = 4'hf;

  // Reset values.
  localparam logic [31:0] REG_RESET = 32'h0000_0000;
  localparam logic [6:0] FLAGS_RESET = 7'h00;

  // Floating-point status register.
  typedef struct packed {
    logic test_flag;
    logic int_zero_flag;
    logic int_negative_flag;
    logic float_zero_flag;
    logic float_negative_flag;
    logic latched_underflow_flag;
    logic latched_overflow_flag;
  } fp_status_register_t;

  // One issued instruction: low word first, high word second.
  typedef struct packed {
    logic [15:0] lsw;
    logic [15:0] msw;
  } instr_t;

  // Register read-back pair.
  typedef struct packed {
    logic [31:0] high;
    logic [31:0] low;
  } reg_pair_t;

  typedef enum logic [2:0] {
    op_none,
    op_half_reg,
    op_word_reg,
    op_half_mem,
    op_word_mem,
    op_clear_one,
    op_clear_all,
    op_cond_load
  } op_t;

  typedef enum logic {
    st_idle,
    st_wait_mem
  } state_t;

endpackage

/* rtl/unused_placeholder_none.sv */
`timescale 1ns/100ps
// Intentionally left with no module; see main file.

/* tb/host_mem_model.sv */
// Behavioural host core data read path for the convert and conditional-load block.
// Assumes the bench supplies the next word and a wait count before each memory request.
`timescale 1ns/100ps
module host_mem_model (
  input wire logic clk_sys, // System clock.
  input wire logic reset, // Synchronous reset, active high.
  input wire logic mem_req, // Operand wanted by the block.
  input wire logic mem_wide, // High for a 32-bit operand.
  input wire logic [31:0] word, // Word handed over on the next request.
  input wire logic [3:0] delay, // Extra wait cycles before delivery.
  output logic mem_rdata_valid, // One-cycle delivery pulse.
  output logic [31:0] mem_rdata // Delivered word, scrambled outside delivery.
);
  logic [3:0] wait_q;

  // One word per request after the chosen wait; outside delivery the data lines toggle every cycle,
  // so a block that samples them at the wrong moment cannot get lucky.
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      wait_q <= 4'h0;
      mem_rdata_valid <= 1'b0;
      mem_rdata <= 32'h0;
    end
    else if (mem_req && !mem_rdata_valid && wait_q == delay)
    begin
      mem_rdata_valid <= 1'b1;
      mem_rdata <= mem_wide ? word : {~word[31:16], word[15:0]};
      wait_q <= 4'h0;
    end
    else
    begin
      mem_rdata_valid <= 1'b0;
      mem_rdata <= ~mem_rdata;
      wait_q <= (mem_req && !mem_rdata_valid) ? wait_q + 4'h1 : 4'h0;
    end
  end
endmodule

/* tb/tb.sv */
// Self-checking bench for the convert, clear and conditional-load block.
// Assumes the package constants and the host memory model; register reads go through rd_sel.
`timescale 1ns/100ps
module tb;
  typedef struct packed {logic [63:0] pair; logic [6:0] fl;} exp_t;
  logic clk_sys, reset, instr_valid, instr_ready, mem_req, mem_wide, mem_rdata_valid, flag_wr, illegal_op;
  logic look, look_d;
  fp_cvt_pkg::instr_t instr;
  logic [7:0] mem_operand;
  logic [31:0] mem_rdata, mdat, w, nv, seed;
  logic [3:0] mdly;
  logic [2:0] rd_sel, s, d;
  fp_cvt_pkg::fp_status_register_t flag_wdata, flags, fl_m;
  fp_cvt_pkg::reg_pair_t rd_data;
  logic [31:0] hi_m [8];
  logic [31:0] lo_m [8];
  exp_t exp_q [$];
  exp_t e_m;
  int errors, n_checks, cycles;

  fp_convert_zero_condmove_ops i_fp_convert_zero_condmove_ops (.clk_sys(clk_sys), .reset(reset),
    .instr_valid(instr_valid), .instr(instr), .instr_ready(instr_ready), .mem_req(mem_req),
    .mem_operand(mem_operand), .mem_wide(mem_wide), .mem_rdata_valid(mem_rdata_valid), .mem_rdata(mem_rdata),
    .flag_wr(flag_wr), .flag_wdata(flag_wdata), .flags(flags), .rd_sel(rd_sel), .rd_data(rd_data),
    .illegal_op(illegal_op));
  host_mem_model i_host_mem_model (.clk_sys(clk_sys), .reset(reset), .mem_req(mem_req), .mem_wide(mem_wide),
    .word(mdat), .delay(mdly), .mem_rdata_valid(mem_rdata_valid), .mem_rdata(mem_rdata));

  // Clock at 10 MHz.
  initial
  begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Unsigned integer to single precision, round to nearest even.
  function automatic logic [31:0] f32(input logic [31:0] v);
    int p;
    logic [31:0] m, rem, half;
    logic [7:0] e;
    if (v == 32'h0)
      return 32'h0;
    p = 31;
    while (!v[p])
      p--;
    e = 8'(127 + p);
    m = (p <= 23) ? v << (23 - p) : v >> (p - 23);
    if (p > 23)
    begin
      rem = v & ((32'h1 << (p - 23)) - 32'h1);
      half = 32'h1 << (p - 24);
      if (rem > half || (rem == half && m[0]))
        m = m + 32'h1;
      if (m[24])
      begin
        m = m >> 1;
        e = e + 8'h1;
      end
    end
    return {1'b0, e, m[22:0]};
  endfunction

  function automatic logic cnd(input logic [3:0] c, input fp_cvt_pkg::fp_status_register_t f);
    case (c)
      fp_cvt_pkg::COND_NEQ: return !f.float_zero_flag;
      fp_cvt_pkg::COND_EQ: return f.float_zero_flag;
      fp_cvt_pkg::COND_GT: return !f.float_zero_flag && !f.float_negative_flag;
      fp_cvt_pkg::COND_GEQ: return !f.float_negative_flag;
      fp_cvt_pkg::COND_LT: return f.float_negative_flag;
      fp_cvt_pkg::COND_LEQ: return f.float_zero_flag || f.float_negative_flag;
      fp_cvt_pkg::COND_TF: return f.test_flag;
      fp_cvt_pkg::COND_NTF: return !f.test_flag;
      fp_cvt_pkg::COND_LU: return f.latched_underflow_flag;
      fp_cvt_pkg::COND_LV: return f.latched_overflow_flag;
      fp_cvt_pkg::ALWAYS_NO_FLAGS, fp_cvt_pkg::ALWAYS_WITH_FLAG_UPDATE: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  task automatic cmp(input string nm, input logic [63:0] e, input logic [63:0] g);
    n_checks++;
    if (g !== e)
    begin
      errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // One bench cycle: offer an instruction and/or ask for a read-back, noting what it must show.
  task automatic step(input logic v, input logic [15:0] l, input logic [15:0] m, input logic c,
    input logic [2:0] sl, input logic [31:0] h);
    instr_valid <= v;
    instr <= {l, m};
    rd_sel <= sl;
    look <= c;
    if (c)
      exp_q.push_back({h, lo_m[sl], fl_m});
    @(posedge clk_sys);
    // A stall that never ends is left to the cycle ceiling, which fails the run.
    while (v && !instr_ready)
    begin
      @(posedge clk_sys);
    end
  endtask

  task automatic op(input logic [15:0] l, input logic [15:0] m);
    step(1'b1, l, m, 1'b0, 3'h0, 32'h0);
  endtask

  task automatic nop();
    step(1'b0, 16'h0, 16'h0, 1'b0, 3'h0, 32'h0);
  endtask

  task automatic chkv(input logic [2:0] sl, input logic [31:0] h);
    step(1'b0, 16'h0, 16'h0, 1'b1, sl, h);
  endtask

  task automatic setfl(input logic [6:0] v);
    flag_wr <= 1'b1;
    flag_wdata <= v;
    fl_m = v;
    @(posedge clk_sys);
    flag_wr <= 1'b0;
  endtask

  // Memory-operand instruction: request shape, stall while waiting, one spare cycle for the landing.
  task automatic mop(input logic [15:0] l, input logic [2:0] dd, input logic [31:0] wd, input logic wide);
    logic [7:0] a;
    a = 8'(xs());
    mdat <= wd;
    mdly <= 4'(xs() & 32'h3);
    op(l, {5'h0, dd, a});
    nop();
    // Read at the edge, so these are the values launched one edge earlier.
    cmp("mem_req", 64'h1, {63'h0, mem_req});
    cmp("mem_wide", {63'h0, wide}, {63'h0, mem_wide});
    cmp("mem_operand", {56'h0, a}, {56'h0, mem_operand});
    cmp("instr_ready", 64'h0, {63'h0, instr_ready});
    while (!instr_ready)
    begin
      @(posedge clk_sys);
    end
    nop();
  endtask

  // Read-back monitor: the oldest note belongs to the read asked for one edge earlier.
  always @(posedge clk_sys)
    look_d <= look;
  always @(negedge clk_sys)
  begin
    if (look_d === 1'b1 && exp_q.size() > 0)
    begin
      e_m = exp_q.pop_front();
      cmp("rd_data", e_m.pair, rd_data);
      cmp("flags", {57'h0, e_m.fl}, {57'h0, flags});
    end
  end

  // A hang is cut short well beyond the few hundred cycles the sequence needs.
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      errors++;
      finish_test();
    end
  end

  initial
  begin
    reset = 1'b1;
    instr_valid = 1'b0;
    instr = '0;
    flag_wr = 1'b0;
    flag_wdata = '0;
    rd_sel = 3'h0;
    look = 1'b0;
    mdat = 32'h0;
    mdly = 4'h0;
    seed = 32'h95f75094;
    fl_m = '0;
    foreach (hi_m[i])
    begin
      hi_m[i] = 32'h0;
      lo_m[i] = 32'h0;
    end
    repeat (5) @(posedge clk_sys);
    reset <= 1'b0;
    for (int i = 0; i < 8; i++)
      chkv(3'(i), 32'h0);
    setfl(7'h55);
    // Fill the high registers from memory; register 1 gets the known half-word case.
    for (int i = 0; i < 8; i++)
    begin
      w = xs();
      if (i == 1)
        mop(fp_cvt_pkg::OPC_HALF_MEM, 3'h1, 32'h5a5a800f, 1'b0);
      else
        mop(fp_cvt_pkg::OPC_WORD_MEM, 3'(i), w, 1'b1);
      hi_m[i] = (i == 1) ? 32'h47000f00 : f32(w);
      chkv(3'(i), hi_m[i]);
    end
    // Register conversions: the delay slot still shows the old value, the cycle after shows the result.
    for (int k = 0; k < 8; k++)
    begin
      s = 3'(xs());
      d = 3'(xs());
      nv = k[0] ? f32(hi_m[s]) : f32({16'h0, hi_m[s][15:0]});
      op(k[0] ? fp_cvt_pkg::OPC_WORD_REG : fp_cvt_pkg::OPC_HALF_REG, {10'h0, s, d});
      chkv(d, hi_m[d]);
      hi_m[d] = nv;
      chkv(d, nv);
      chkv(d, nv);
    end
    // Conditional low-half load over every condition code, reserved ones included.
    for (int c = 0; c < 32; c++)
    begin
      setfl(7'(xs()));
      w = ((xs() & 32'h3) == 32'h0) ? {xs() & 32'h807fffff} : xs();
      d = 3'(xs());
      mop({fp_cvt_pkg::OPC_COND_LOAD_TOP, 4'(c / 2)}, d, w, 1'b1);
      if (cnd(4'(c / 2), fl_m))
        lo_m[d] = w;
      if (4'(c / 2) == fp_cvt_pkg::ALWAYS_WITH_FLAG_UPDATE)
      begin
        fl_m.float_zero_flag = (w[30:23] == 8'h0);
        fl_m.float_negative_flag = w[31] && (w[30:23] != 8'h0);
        fl_m.int_negative_flag = w[31];
        fl_m.int_zero_flag = (w == 32'h0);
      end
      chkv(d, hi_m[d]);
    end
    // Single clears take effect for the very next instruction; neighbours keep their values.
    for (int i = 0; i < 4; i++)
    begin
      op({fp_cvt_pkg::OPC_CLEAR_ONE_TOP, 3'(i)}, 16'h0);
      hi_m[i] = 32'h0;
      chkv(3'(i), 32'h0);
      chkv(3'(i), 32'h0);
      chkv(3'(i + 4), hi_m[i + 4]);
    end
    setfl(7'h2b);
    op(fp_cvt_pkg::OPC_CLEAR_ALL, 16'h0);
    chkv(3'h7, 32'h0);
    for (int i = 0; i < 8; i++)
      chkv(3'(i), 32'h0);
    // An unknown opcode is taken, flagged for one cycle and changes nothing.
    op(16'h0123, 16'h0000);
    chkv(3'h0, 32'h0);
    cmp("illegal_op", 64'h1, {63'h0, illegal_op});
    chkv(3'h0, 32'h0);
    cmp("illegal_op", 64'h0, {63'h0, illegal_op});
    nop();
    nop();
    finish_test();
  end
endmodule
